// ### core/mra_pkg.sv
// Constants and types of the management register access layer.
// Assumes a 10 MHz system clock and a two-wire management link.
package mra_pkg;
  localparam int unsigned CLK_MHZ     = 10;
  localparam int unsigned HOLDOFF_NS  = 10000;
  localparam int unsigned HOLDOFF_CYC = (HOLDOFF_NS * CLK_MHZ / 1000 < 1) ? 1 : HOLDOFF_NS * CLK_MHZ / 1000;
  localparam int unsigned MEM_BYTES   = 256;
  localparam logic [7:0]  LOWER_END   = 8'h7f;
  localparam logic [7:0]  UPPER_BASE  = 8'h80;
  localparam logic [7:0]  NMAX_BASE   = 8'h08;
  localparam logic [7:0]  NMAX_PAGE   = 8'h80;
  localparam logic [3:0]  WBUF_BYTES  = 4'h8;
  localparam logic [6:0]  DEV_ADDR    = 7'h50;
  localparam logic [7:0]  COR_ADDR    = 8'h08;
  localparam logic [7:0]  TX_PAD      = 8'hff;
  localparam logic [2:0]  BIT_LAST    = 3'h7;
  localparam logic [1:0]  PH_DEV      = 2'h0;
  localparam logic [1:0]  PH_REG      = 2'h1;
  localparam logic [1:0]  PH_DATA     = 2'h2;

  typedef enum logic [4:0] {
    MRA_IDLE = 5'h01,
    MRA_RX   = 5'h02,
    MRA_ACK  = 5'h04,
    MRA_TX   = 5'h08,
    MRA_MACK = 5'h10
  } mra_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } mra_upd_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [3:0] len;
  } mra_wr_t;
endpackage

// ### core/mra_core.sv
// Register access layer: two-wire management link slave over a 256-byte memory.
// Assumes link pins arrive asynchronously; internal logic updates bytes via a handshake port.
// Operation
// - Memory holds 256 bytes, lower half 00-7F, upper half 80-FF.
// - A read moves one to eight bytes, or up to 128 with full-page read.
// - A read without address starts at the kept current address.
// - Read side effects such as clear-on-read may finish after the read.
// - A refused read is signalled distinctly from any byte data.
// - An accepted write stores up to eight bytes from the given address.
// - A refused write changes nothing and reports failure.
// - A readiness probe tells whether a read or write would be accepted.
// - After a write accesses are refused, at most for the hold-off time.
// - A written byte reads back exactly as written.
// - Any part of a written range reads back as written.
// - Until read-back is ensured, the next access is refused or stretched.
// - Write effects are not synchronised; a dedicated handshake reports them.
// - Single-byte reads and writes are atomic against internal updates.
// - Size-matched reads of status registers see no update during the read.
// - Other multi-byte reads carry no coherency guarantee.
// - Multi-byte writes are applied together in one cycle.
// - Full-page read is supported as a build option.
`timescale 1ns/1ps
`default_nettype none
module mra_core #(
  parameter int unsigned HOLDOFF_CYC_P = mra_pkg::HOLDOFF_CYC,
  parameter logic        FULL_PAGE     = 1'b1
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  // Management link
  input  wire logic             link_scl,
  input  wire logic             link_sda_i,
  output logic                  link_sda_o,
  output logic                  link_sda_oe,
  // Internal update port
  input  wire logic             upd_valid,
  input  wire mra_pkg::mra_upd_t upd,
  output logic                  upd_ready,
  // Write completion report
  output logic                  wr_done,
  output mra_pkg::mra_wr_t      wr_info
);
  import mra_pkg::*;

  localparam int unsigned HW   = $clog2(HOLDOFF_CYC_P + 1);
  localparam logic [7:0]  NMAX = FULL_PAGE ? NMAX_PAGE : NMAX_BASE;

  logic [7:0]    mem [MEM_BYTES];
  logic [7:0]    wbuf_q [WBUF_BYTES];
  logic [2:0]    scl_r;
  logic [2:0]    sda_r;
  mra_state_t    st_q;
  logic [1:0]    phase_q;
  logic [2:0]    bit_q;
  logic [7:0]    sh_q;
  logic          rw_q;
  logic          ack_q;
  logic          drv_q;
  logic          rd_act_q;
  logic          wact_q;
  logic [7:0]    cur_q;
  logic [7:0]    waddr_q;
  logic [3:0]    wcnt_q;
  logic [7:0]    rcnt_q;
  logic          sda_oe_q;
  logic [HW-1:0] holdoff_q;
  logic          cor_pend_q;
  logic          cor_pend_d;
  logic          wr_done_q;
  mra_wr_t       wr_info_q;

  wire scl      = scl_r[1];
  wire scl_p    = scl_r[2];
  wire sda      = sda_r[1];
  wire sda_p    = sda_r[2];
  wire rise     = scl & ~scl_p;
  wire fall     = ~scl & scl_p;
  wire start    = scl & scl_p & sda_p & ~sda;
  wire stop     = scl & scl_p & ~sda_p & sda;
  wire ender    = start | stop;
  wire [7:0] rx_byte = {sh_q[6:0], sda};
  wire busy     = holdoff_q != '0;
  wire dev_hit  = rx_byte[7:1] == DEV_ADDR;
  wire ack_dev  = dev_hit & ~busy;
  wire wr_room  = wcnt_q < WBUF_BYTES;
  wire stage    = (st_q == MRA_RX) & rise & (bit_q == BIT_LAST) & (phase_q == PH_DATA) & wr_room;
  wire rx_ack   = (phase_q == PH_DEV) ? ack_dev : ((phase_q == PH_REG) ? 1'b1 : wr_room);
  wire in_lim   = rcnt_q < NMAX;
  wire [7:0] tx_byte = in_lim ? mem[cur_q] : TX_PAD;
  wire tx_load  = fall & ack_q & (((st_q == MRA_ACK) & drv_q & rw_q) | (st_q == MRA_MACK));
  wire commit   = ender & wact_q & (wcnt_q != 4'h0);
  wire cor_fire = cor_pend_q & ~rd_act_q & ~commit;

  // Two-stage pin synchronisers plus a history stage
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_r <= 3'h7;
      sda_r <= 3'h7;
    end else begin
      scl_r <= {scl_r[1:0], link_scl};
      sda_r <= {sda_r[1:0], link_sda_i};
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q      <= MRA_IDLE;
      phase_q   <= PH_DEV;
      bit_q     <= 3'h0;
      sh_q      <= 8'h00;
      rw_q      <= 1'b0;
      ack_q     <= 1'b0;
      drv_q     <= 1'b0;
      rd_act_q  <= 1'b0;
      wact_q    <= 1'b0;
      cur_q     <= 8'h00;
      waddr_q   <= 8'h00;
      wcnt_q    <= 4'h0;
      rcnt_q    <= 8'h00;
      sda_oe_q  <= 1'b0;
      wr_done_q <= 1'b0;
      wr_info_q <= '0;
    end else begin
      wr_done_q <= commit;
      if (commit) begin
        wr_info_q <= '{addr: waddr_q, len: wcnt_q};
      end
      if (ender) begin
        st_q     <= start ? MRA_RX : MRA_IDLE;
        phase_q  <= PH_DEV;
        bit_q    <= 3'h0;
        sda_oe_q <= 1'b0;
        rd_act_q <= 1'b0;
        wact_q   <= 1'b0;
        wcnt_q   <= 4'h0;
        if (commit) begin
          cur_q <= 8'(waddr_q + {4'h0, wcnt_q});
        end
      end else begin
        unique case (st_q)
          MRA_IDLE: begin
          end
          MRA_RX: if (rise) begin
            sh_q  <= rx_byte;
            bit_q <= 3'(bit_q + 3'h1);
            if (bit_q == BIT_LAST) begin
              st_q  <= MRA_ACK;
              ack_q <= rx_ack;
              drv_q <= 1'b0;
              if (phase_q == PH_DEV) begin
                rw_q     <= rx_byte[0];
                rd_act_q <= ack_dev & rx_byte[0];
                wact_q   <= ack_dev & ~rx_byte[0];
                rcnt_q   <= 8'h00;
              end
              if (phase_q == PH_REG) begin
                cur_q   <= rx_byte;
                waddr_q <= rx_byte;
              end
              if (stage) begin
                wcnt_q <= 4'(wcnt_q + 4'h1);
              end
            end
          end
          MRA_ACK: if (fall) begin
            if (!drv_q) begin
              sda_oe_q <= ack_q;
              drv_q    <= 1'b1;
            end else if (!ack_q) begin
              sda_oe_q <= 1'b0;
              st_q     <= MRA_IDLE;
            end else if (!rw_q) begin
              sda_oe_q <= 1'b0;
              st_q     <= MRA_RX;
              phase_q  <= (phase_q == PH_DEV) ? PH_REG : PH_DATA;
            end
          end
          MRA_TX: if (fall) begin
            bit_q <= 3'(bit_q + 3'h1);
            sh_q  <= {sh_q[6:0], 1'b0};
            if (bit_q == BIT_LAST) begin
              sda_oe_q <= 1'b0;
              st_q     <= MRA_MACK;
            end else begin
              sda_oe_q <= ~sh_q[6];
            end
          end
          MRA_MACK: begin
            if (rise) begin
              ack_q <= ~sda;
            end else if (fall && !ack_q) begin
              st_q <= MRA_IDLE;
            end
          end
        endcase
        if (tx_load) begin
          sh_q     <= tx_byte;
          sda_oe_q <= ~tx_byte[7];
          bit_q    <= 3'h0;
          st_q     <= MRA_TX;
          cur_q    <= 8'(cur_q + 8'h01);
          rcnt_q   <= in_lim ? 8'(rcnt_q + 8'h01) : rcnt_q;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      holdoff_q <= '0;
    end else if (commit) begin
      holdoff_q <= HW'(HOLDOFF_CYC_P);
    end else if (busy) begin
      holdoff_q <= HW'(holdoff_q - 1'b1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (stage) begin
      wbuf_q[wcnt_q[2:0]] <= rx_byte;
    end
  end

  assign cor_pend_d = (tx_load & in_lim & (cur_q == COR_ADDR)) | (cor_pend_q & ~cor_fire);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cor_pend_q <= 1'b0;
    end else begin
      cor_pend_q <= cor_pend_d;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < MEM_BYTES; i++) begin
        mem[i] <= 8'h00;
      end
    end else if (commit) begin
      for (int i = 0; i < WBUF_BYTES; i++) begin
        if (4'(i) < wcnt_q) begin
          mem[8'(waddr_q + 8'(i))] <= wbuf_q[i];
        end
      end
    end else if (cor_fire) begin
      mem[COR_ADDR] <= 8'h00;
    end else if (upd_valid && upd_ready) begin
      mem[upd.addr] <= upd.data;
    end
  end

  // internal updates wait out a read
  assign upd_ready   = ~rd_act_q & ~commit & ~cor_fire;
  assign link_sda_o  = 1'b0;
  assign link_sda_oe = sda_oe_q;
  assign wr_done     = wr_done_q;
  assign wr_info     = wr_info_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_commit;
    commit ##1 wr_done;
  endsequence
  sequence s_busy3;
    busy [*3];
  endsequence

  property p_holdoff;
    s_commit |-> s_busy3;
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("hold-off not started after write");

  property p_holdoff_max;
    holdoff_q <= HW'(HOLDOFF_CYC_P);
  endproperty
  a_holdoff_max: assert property (p_holdoff_max) else $error("hold-off too long");

  property p_refuse_busy;
    (st_q == MRA_RX && rise && bit_q == BIT_LAST && phase_q == PH_DEV && busy) |=> !ack_q;
  endproperty
  a_refuse_busy: assert property (p_refuse_busy) else $error("busy device acknowledged");

  property p_cur_adv;
    commit |=> cur_q == 8'($past(waddr_q) + {4'h0, $past(wcnt_q)});
  endproperty
  a_cur_adv: assert property (p_cur_adv) else $error("current address not advanced");

  property p_no_upd_read;
    rd_act_q |-> !upd_ready;
  endproperty
  a_no_upd_read: assert property (p_no_upd_read) else $error("update during read");

  property p_wr_len;
    wr_done |-> (wr_info.len != 4'h0 && wr_info.len <= WBUF_BYTES);
  endproperty
  a_wr_len: assert property (p_wr_len) else $error("bad write length");

  property p_rd_limit;
    rcnt_q <= NMAX;
  endproperty
  a_rd_limit: assert property (p_rd_limit) else $error("read count over limit");

  property p_cor_done;
    (cor_pend_q && !rd_act_q && !commit) |=> !cor_pend_q;
  endproperty
  a_cor_done: assert property (p_cor_done) else $error("clear-on-read not applied");

  property p_drive_phase;
    link_sda_oe |-> (st_q == MRA_ACK || st_q == MRA_TX);
  endproperty
  a_drive_phase: assert property (p_drive_phase) else $error("data line driven off phase");

endmodule
`default_nettype wire

// ### verification/mra_host_model.sv
// Host controller model for the two-wire management link.
// Assumes a pull-up on the data wire, resolved by the bench from both enables.
`timescale 1ns/1ps
`default_nettype none
module mra_host_model (
  // Link pins
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  localparam int QTR = 200;

  // Link clock stands high between frames
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic start();
    sda_low = 1'b1;
    #QTR scl = 1'b0;
  endtask

  // Extra wait lets the device release the wire after its acknowledge
  task automatic rstart();
    #(2*QTR) sda_low = 1'b0;
    #QTR scl = 1'b1;
    #QTR sda_low = 1'b1;
    #QTR scl = 1'b0;
  endtask

  task automatic stop();
    sda_low = 1'b1;
    #(2*QTR) scl = 1'b1;
    #QTR sda_low = 1'b0;
    #(2*QTR);
  endtask

  // One clock of 800 ns, data changed only while the clock is low
  task automatic bit_io(input logic b, output logic s);
    #QTR sda_low = ~b;
    #QTR scl = 1'b1;
    #(2*QTR) s = sda;
    scl = 1'b0;
  endtask

  // host writes only plain read-write bytes
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = (s === 1'b0);
  endtask

  task automatic recv(output logic [7:0] b, input logic last);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(last, s);
  endtask
endmodule
`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench for the management register access layer.
// Assumes the host model as link partner and a pull-up on the data wire.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mra_pkg::*;
  localparam int HOLD = 100;
  logic     sys_clk, sys_rst, scl, host_low, sda, sda_o, sda_oe, upd_valid, upd_ready, wr_done, ack;
  mra_upd_t upd;
  mra_wr_t  wr_info, last_info;
  int       err_count, total_checks, done_cnt;
  logic [7:0] rd [0:15];

  assign sda = ~(host_low | (sda_oe & ~sda_o));

  mra_core #(.HOLDOFF_CYC_P(HOLD), .FULL_PAGE(1'b1)) mra_core_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .link_scl(scl), .link_sda_i(sda),
    .link_sda_o(sda_o), .link_sda_oe(sda_oe), .upd_valid(upd_valid), .upd(upd),
    .upd_ready(upd_ready), .wr_done(wr_done), .wr_info(wr_info));
  mra_host_model host_inst (.scl(scl), .sda_low(host_low), .sda(sda));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  always @(negedge sys_clk) begin
    if (wr_done === 1'b1) begin
      done_cnt++;
      last_info = wr_info;
    end
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    if (err_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input int n, input logic [7:0] base, output logic ok);
    @(posedge sys_clk) #1;
    host_inst.start();
    host_inst.send(8'ha0, ok);
    if (ok) begin
      host_inst.send(a, ack);
      for (int i = 0; i < n; i++) host_inst.send(8'(base + i), ack);
    end
    host_inst.stop();
  endtask

  task automatic rdn(input logic ra, input logic [7:0] a, input int n, output logic ok);
    @(posedge sys_clk) #1;
    ok = 1'b1;
    host_inst.start();
    if (ra) begin
      host_inst.send(8'ha0, ok);
      if (ok) begin
        host_inst.send(a, ack);
        host_inst.rstart();
      end
    end
    if (ok) host_inst.send(8'ha1, ok);
    if (ok) begin
      check("upd_ready in read", 16'h0, {15'h0, upd_ready});
      for (int i = 0; i < n; i++) host_inst.recv(rd[i], i == n - 1);
    end
    host_inst.stop();
  endtask

  task automatic t_write_readback();
    logic ok;
    wr(8'h7c, 8, 8'h10, ok);
    check("write accepted", 16'h1, {15'h0, ok});
    repeat (4) @(posedge sys_clk);
    check("commit info", {4'h0, 8'h7c, 4'h8}, {4'h0, last_info});
    wr(8'h7c, 1, 8'hee, ok);
    check("held-off write", 16'h0, {15'h0, ok});
    check("commit count", 16'h1, 16'(done_cnt));
    @(posedge sys_clk) #1;
    host_inst.start();
    host_inst.send(8'ha0, ok);
    host_inst.stop();
    check("probe ready", 16'h1, {15'h0, ok});
    rdn(1'b1, 8'h7c, 4, ok);
    for (int i = 0; i < 4; i++) check("read back", 16'(8'h10 + i), {8'h0, rd[i]});
    rdn(1'b0, 8'h00, 4, ok);
    for (int i = 0; i < 4; i++) check("current read", 16'(8'h14 + i), {8'h0, rd[i]});
  endtask

  task automatic t_ninth_byte();
    logic ok;
    repeat (HOLD) @(posedge sys_clk);
    wr(8'h20, 9, 8'h40, ok);
    check("ninth byte ack", 16'h0, {15'h0, ack});
    repeat (4) @(posedge sys_clk);
    check("eight committed", {4'h0, 8'h20, 4'h8}, {4'h0, last_info});
    rdn(1'b1, 8'h20, 9, ok);
    check("held-off read", 16'h0, {15'h0, ok});
    for (int i = 0; i < 3 && ok !== 1'b1; i++) rdn(1'b1, 8'h20, 9, ok);
    check("read retried", 16'h1, {15'h0, ok});
    for (int i = 0; i < 9; i++) check("long read", (i < 8) ? 16'(8'h40 + i) : 16'h0, {8'h0, rd[i]});
  endtask

  task automatic t_update_clear();
    logic ok;
    @(posedge sys_clk) #1;
    upd_valid = 1'b1;
    upd = '{addr: COR_ADDR, data: 8'h77};
    for (int i = 0; i < 20 && upd_ready !== 1'b1; i++) @(posedge sys_clk) #1;
    @(posedge sys_clk) #1;
    upd_valid = 1'b0;
    rdn(1'b1, COR_ADDR, 1, ok);
    check("updated byte", 16'h77, {8'h0, rd[0]});
    repeat (10) @(posedge sys_clk);
    rdn(1'b1, COR_ADDR, 1, ok);
    check("cleared byte", 16'h0, {8'h0, rd[0]});
  endtask

  initial begin
    #3_000_000;
    err_count++;
    test_done();
  end

  initial begin
    err_count = 0;
    total_checks = 0;
    done_cnt = 0;
    sys_rst = 1'b1;
    upd_valid = 1'b0;
    upd = '0;
    repeat (3) @(posedge sys_clk);
    #1;
    check("reset outputs", 16'h0001, {1'h0, sda_oe, wr_done, wr_info, upd_ready});
    sys_rst = 1'b0;
    repeat (5) @(posedge sys_clk);
    t_write_readback();
    t_ninth_byte();
    t_update_clear();
    test_done();
  end
endmodule
`default_nettype wire
